// [design/pffl_crc_check.sv]
// crc address range check and launch
`default_nettype none
module pffl_crc_check (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // request
  input wire logic start,
  input wire logic [31:0] starting_address,
  input wire logic [31:0] ending_address,
  // result pulses
  output logic go,
  output logic abort
);
  logic next_go;
  logic next_abort;
  logic bad_range;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // widened sum so the top address cannot wrap to a false pass
    bad_range = {1'b0, ending_address} <
      ({1'b0, starting_address} + 33'h000000001); // R07
    next_abort = start && bad_range; // R07
    next_go = start && !bad_range;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      go <= 1'b0;
      abort <= 1'b0;
    end
    else
    begin
      go <= next_go;
      abort <= next_abort;
    end
  end
endmodule
`default_nettype wire

// [design/pffl_flag_core.sv]
// program fail and buffer abort flags
`default_nettype none
module pffl_flag_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // flag events
  pffl_flag_if.core fl
);
  logic program_fail_flag;
  logic buffer_abort_flag;
  logic next_program_fail_flag;
  logic next_buffer_abort_flag;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // set beats clear so a same-cycle failure is never lost
    next_program_fail_flag = program_fail_flag;
    if (fl.clear)
      next_program_fail_flag = 1'b0; // R03
    if (fl.fail_set)
      next_program_fail_flag = 1'b1; // R01 R02 R10
    next_buffer_abort_flag = buffer_abort_flag;
    if (fl.clear || fl.prog_ok)
      next_buffer_abort_flag = 1'b0; // R06
    if (fl.abort_set)
      next_buffer_abort_flag = 1'b1; // R11
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      program_fail_flag <= pffl_pkg::FLAG_RST;
      buffer_abort_flag <= pffl_pkg::FLAG_RST;
    end
    else
    begin
      program_fail_flag <= next_program_fail_flag;
      buffer_abort_flag <= next_buffer_abort_flag;
    end
  end

  assign fl.program_fail_flag = program_fail_flag;
  assign fl.buffer_abort_flag = buffer_abort_flag;
endmodule
`default_nettype wire

// [design/pffl_flag_if.sv]
// carrier between the top and the flag core
`default_nettype none
interface pffl_flag_if;
  logic fail_set;
  logic abort_set;
  logic prog_ok;
  logic clear;
  logic program_fail_flag;
  logic buffer_abort_flag;
  modport core (input fail_set, abort_set, prog_ok, clear,
    output program_fail_flag, buffer_abort_flag);
  modport ctl (output fail_set, abort_set, prog_ok, clear,
    input program_fail_flag, buffer_abort_flag);
endinterface
`default_nettype wire

// [design/pffl_pkg.sv]
// constants for the flash program status flag block
//
// Overview of operation
// [R01] a failed program sets the program fail flag, status bit 4
// [R02] program attempt on a protected region also sets the program fail flag
// [R03] program fail flag clears only by clear status command or reset
// [R04] standby is entered only while the program fail flag is clear
// [R05] write buffer abort stops the buffer at once, sets both flags
// [R06] next good program or clear status command clears buffer abort
// [R07] crc with ending below starting plus one aborts, readies, sets abort
// [R08] host treats crc result as undefined after an aborted calculation
// [R09] host should give an ending address above the starting address
// [R10] program fail flag reads zero after success, one after failure
// [R11] buffer abort flag reads one after buffer or crc abort, else zero
// [R12] status marked not valid during reset, deep power-down exit, cs reset
// [R13] host reads status after each program or crc and checks both flags
`default_nettype none
package pffl_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int EVT_W = 4;
  // register byte offsets
  localparam logic [4:0] OFF_STATUS = 5'h00;
  localparam logic [4:0] OFF_CTRL = 5'h04;
  localparam logic [4:0] OFF_EVT = 5'h08;
  localparam logic [4:0] OFF_MASK = 5'h0C;
  localparam logic [4:0] OFF_SADDR = 5'h10;
  localparam logic [4:0] OFF_EADDR = 5'h14;
  // status register fields
  localparam int STAT_PRG_BIT = 4;
  localparam int STAT_ABT_BIT = 3;
  // control register fields
  localparam int CTRL_CLR_BIT = 0;
  localparam int CTRL_SRST_BIT = 1;
  localparam int CTRL_CRC_BIT = 2;
  localparam int CTRL_STBY_BIT = 3;
  // event status fields
  localparam int EVT_PRG_BIT = 0;
  localparam int EVT_ABT_BIT = 1;
  localparam int EVT_CRC_BIT = 2;
  localparam int EVT_STBY_BIT = 3;
  // reset values
  localparam logic FLAG_RST = 1'b0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [31:0] ADDR_RST = 32'h00000000;
  typedef enum logic {PFFL_BUS_IDLE = 1'b0, PFFL_BUS_DONE = 1'b1} pffl_bus_t;
endpackage
`default_nettype wire

// [design/pffl_top.sv]
// flash program status flags with avalon register slave
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`default_nettype none
module pffl_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // program engine
  input wire logic prog_end,
  input wire logic prog_failed,
  input wire logic prog_protected,
  input wire logic wrbuf_active,
  input wire logic wrbuf_abort_cond,
  output logic wrbuf_stop,
  // crc engine
  input wire logic crc_done,
  output logic crc_start,
  output logic crc_ready,
  // power and reset events
  input wire logic cs_reset,
  input wire logic dpd_exit,
  output logic standby_enter,
  output logic status_valid,
  // interrupt
  output logic irq
);
  pffl_flag_if fl ();

  pffl_pkg::pffl_bus_t bus_state;
  pffl_pkg::pffl_bus_t next_bus_state;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic [31:0] starting_address;
  logic [31:0] ending_address;
  logic [31:0] next_starting_address;
  logic [31:0] next_ending_address;
  logic [3:0] evt_status;
  logic [3:0] evt_mask;
  logic [3:0] next_evt_status;
  logic [3:0] next_evt_mask;
  logic [3:0] evt_set;
  logic standby_request;
  logic next_standby_request;
  logic next_standby_enter;
  logic next_status_valid;
  logic next_irq;
  logic next_wrbuf_stop;
  logic next_crc_ready;
  logic [7:0] status_byte;
  logic take;
  logic wr_ctrl;
  logic wr_evt;
  logic wr_mask;
  logic wr_saddr;
  logic wr_eaddr;
  logic clear_status_command;
  logic soft_reset;
  logic crc_req;
  logic crc_go;
  logic crc_abort;
  logic buf_abort;

  ////////////////////////////////////////////////////////////////////////
  // submodules

  pffl_flag_core u_flags (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .fl(fl.core)
  );

  pffl_crc_check u_crc (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(crc_req),
    .starting_address(starting_address),
    .ending_address(ending_address),
    .go(crc_go),
    .abort(crc_abort)
  );

  ////////////////////////////////////////////////////////////////////////
  // write decode, effective at the edge that sees waitrequest low

  always_comb
  begin
    take = (bus_state == pffl_pkg::PFFL_BUS_DONE) && avs_write;
    wr_ctrl = 1'b0;
    wr_evt = 1'b0;
    wr_mask = 1'b0;
    wr_saddr = 1'b0;
    wr_eaddr = 1'b0;
    if (!take)
      wr_ctrl = 1'b0;
    else if (avs_address == pffl_pkg::OFF_CTRL)
      wr_ctrl = 1'b1;
    else if (avs_address == pffl_pkg::OFF_EVT)
      wr_evt = 1'b1;
    else if (avs_address == pffl_pkg::OFF_MASK)
      wr_mask = 1'b1;
    else if (avs_address == pffl_pkg::OFF_SADDR)
      wr_saddr = 1'b1;
    else if (avs_address == pffl_pkg::OFF_EADDR)
      wr_eaddr = 1'b1;
    clear_status_command = wr_ctrl && avs_writedata[pffl_pkg::CTRL_CLR_BIT];
    soft_reset = wr_ctrl && avs_writedata[pffl_pkg::CTRL_SRST_BIT];
    crc_req = wr_ctrl && avs_writedata[pffl_pkg::CTRL_CRC_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // flag events into the core

  always_comb
  begin
    // abort counts only while a buffer program is running
    buf_abort = wrbuf_active && wrbuf_abort_cond;
    fl.fail_set = (prog_end && prog_failed) || prog_protected // R01 R02
      || buf_abort; // R05
    fl.abort_set = buf_abort || crc_abort; // R05 R07 R11
    fl.prog_ok = prog_end && !prog_failed && !prog_protected; // R06
    // cs signalling reset acts as a hardware reset of the flags
    fl.clear = clear_status_command || soft_reset || cs_reset; // R03 R06
  end

  ////////////////////////////////////////////////////////////////////////
  // status byte, only bits 4 and 3 live here

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[pffl_pkg::STAT_PRG_BIT] = fl.program_fail_flag; // R10
    status_byte[pffl_pkg::STAT_ABT_BIT] = fl.buffer_abort_flag; // R11
  end

  ////////////////////////////////////////////////////////////////////////
  // engine controls, standby, validity

  always_comb
  begin
    next_wrbuf_stop = buf_abort; // R05
    next_crc_ready = crc_ready;
    if (crc_done)
      next_crc_ready = 1'b1;
    if (crc_go)
      next_crc_ready = 1'b0;
    if (crc_abort)
      next_crc_ready = 1'b1; // R07
    next_standby_request = standby_request;
    if (wr_ctrl)
      next_standby_request = avs_writedata[pffl_pkg::CTRL_STBY_BIT];
    if (soft_reset || cs_reset)
      next_standby_request = 1'b0;
    // a pending failure holds the part awake until cleared
    next_standby_enter = standby_request && !fl.program_fail_flag; // R04
    next_status_valid = !(cs_reset || dpd_exit); // R12
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wrbuf_stop <= 1'b0;
      crc_start <= 1'b0;
      crc_ready <= 1'b1;
      standby_request <= 1'b0;
      standby_enter <= 1'b0;
      status_valid <= 1'b0; // R12
    end
    else
    begin
      wrbuf_stop <= next_wrbuf_stop;
      crc_start <= crc_go;
      crc_ready <= next_crc_ready;
      standby_request <= next_standby_request;
      standby_enter <= next_standby_enter;
      status_valid <= next_status_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event status, mask, interrupt

  always_comb
  begin
    evt_set = 4'h0;
    evt_set[pffl_pkg::EVT_PRG_BIT] = fl.fail_set;
    evt_set[pffl_pkg::EVT_ABT_BIT] = buf_abort;
    evt_set[pffl_pkg::EVT_CRC_BIT] = crc_abort;
    evt_set[pffl_pkg::EVT_STBY_BIT] = next_standby_enter && !standby_enter;
    next_evt_status = evt_status;
    if (wr_evt)
      next_evt_status = evt_status & ~avs_writedata[3:0];
    // set wins over a write-one-to-clear in the same cycle
    next_evt_status = next_evt_status | evt_set;
    next_evt_mask = wr_mask ? avs_writedata[3:0] : evt_mask;
    next_irq = |(next_evt_status & next_evt_mask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      evt_status <= 4'h0;
      evt_mask <= pffl_pkg::MASK_RST;
      irq <= 1'b0;
    end
    else
    begin
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crc address registers

  always_comb
  begin
    next_starting_address = wr_saddr ? avs_writedata : starting_address;
    next_ending_address = wr_eaddr ? avs_writedata : ending_address;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      starting_address <= pffl_pkg::ADDR_RST;
      ending_address <= pffl_pkg::ADDR_RST;
    end
    else
    begin
      starting_address <= next_starting_address;
      ending_address <= next_ending_address;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then a single answer cycle

  always_comb
  begin
    next_bus_state = bus_state;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    case (bus_state)
      pffl_pkg::PFFL_BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          next_bus_state = pffl_pkg::PFFL_BUS_DONE;
          next_waitrequest = 1'b0;
          next_readdata = 32'h00000000;
          if (!avs_read)
            next_readdata = 32'h00000000;
          else if (avs_address == pffl_pkg::OFF_STATUS)
            next_readdata = {24'h000000, status_byte};
          else if (avs_address == pffl_pkg::OFF_CTRL)
            next_readdata = {28'h0000000, standby_request, 3'h0};
          else if (avs_address == pffl_pkg::OFF_EVT)
            next_readdata = {28'h0000000, evt_status};
          else if (avs_address == pffl_pkg::OFF_MASK)
            next_readdata = {28'h0000000, evt_mask};
          else if (avs_address == pffl_pkg::OFF_SADDR)
            next_readdata = starting_address;
          else if (avs_address == pffl_pkg::OFF_EADDR)
            next_readdata = ending_address;
        end
      end
      pffl_pkg::PFFL_BUS_DONE:
      begin
        next_bus_state = pffl_pkg::PFFL_BUS_IDLE;
        next_waitrequest = 1'b1;
      end
      default:
      begin
        next_bus_state = pffl_pkg::PFFL_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      bus_state <= pffl_pkg::PFFL_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      bus_state <= next_bus_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end
endmodule
`default_nettype wire

// [verification/pffl_asserts.sv]
// port assertions for the program status flag block
`default_nettype none
module pffl_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // watched ports
  input wire logic avs_waitrequest,
  input wire logic prog_end,
  input wire logic prog_failed,
  input wire logic prog_protected,
  input wire logic wrbuf_active,
  input wire logic wrbuf_abort_cond,
  input wire logic wrbuf_stop,
  input wire logic crc_done,
  input wire logic crc_start,
  input wire logic crc_ready,
  input wire logic cs_reset,
  input wire logic dpd_exit,
  input wire logic standby_enter,
  input wire logic status_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_stop_follows: assert property (wrbuf_abort_cond && wrbuf_active |=>
    wrbuf_stop) else $error("stop missing after abort");
  a_stop_cause: assert property (wrbuf_stop |-> $past(wrbuf_active) &&
    $past(wrbuf_abort_cond)) else $error("stop without abort");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_start_busy: assert property (crc_start |-> !crc_ready)
    else $error("ready during launch");
  a_done_ready: assert property (crc_done |=> crc_ready)
    else $error("ready missing after done");
  a_fail_standby: assert property (prog_end && prog_failed && !cs_reset
    |=> ##1 !standby_enter) else $error("standby with fail flag");
  a_prot_standby: assert property (prog_protected && !cs_reset
    |=> ##1 !standby_enter) else $error("standby after protect");
  a_cs_invalid: assert property (cs_reset |=> !status_valid)
    else $error("status valid after cs reset");
  a_dpd_invalid: assert property (dpd_exit |=> !status_valid)
    else $error("status valid in dpd exit");
endmodule
bind pffl_top pffl_asserts u_asserts (.clk_sys, .reset_n, .avs_waitrequest,
  .prog_end, .prog_failed, .prog_protected, .wrbuf_active, .wrbuf_abort_cond,
  .wrbuf_stop, .crc_done, .crc_start, .crc_ready, .cs_reset, .dpd_exit,
  .standby_enter, .status_valid);
`default_nettype wire

// [verification/pffl_crc_model.sv]
// crc engine model answering launch pulses
`default_nettype none
module pffl_crc_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // engine handshake
  input wire logic crc_start,
  input wire logic [7:0] lat,
  output logic crc_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  // only a done pulse comes back, no result that an abort could spoil
  always @(posedge clk_sys)
  begin
    crc_done <= reset_n && !crc_start && (cnt == 8'h01);
    if (!reset_n)
      cnt <= 8'h00;
    else if (crc_start)
      cnt <= lat;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
endmodule
`default_nettype wire

// [verification/tb.sv]
// testbench for the program status flag block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest, wrbuf_active;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_v;
  logic prog_end, prog_failed, prog_protected, wrbuf_abort_cond, wrbuf_stop;
  logic crc_done, crc_start, crc_ready, cs_reset, dpd_exit, standby_enter;
  logic status_valid, irq;
  logic [5:0] evs;
  logic [7:0] lat;
  int fails = 0;
  int n_compared = 0;
  localparam logic [31:0] PF = 32'h1 << pffl_pkg::STAT_PRG_BIT;
  localparam logic [31:0] AB = 32'h1 << pffl_pkg::STAT_ABT_BIT;
  localparam logic [4:0] ST = pffl_pkg::OFF_STATUS;
  localparam logic [4:0] CT = pffl_pkg::OFF_CTRL;
  assign {dpd_exit, cs_reset, wrbuf_abort_cond} = evs[5:3];
  assign {prog_protected, prog_failed, prog_end} = evs[2:0];
  pffl_top DUT (.clk_sys, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .prog_end, .prog_failed,
    .prog_protected, .wrbuf_active, .wrbuf_abort_cond, .wrbuf_stop, .crc_done,
    .crc_start, .crc_ready, .cs_reset, .dpd_exit, .standby_enter,
    .status_valid, .irq);
  pffl_crc_model u_crc (.clk_sys, .reset_n, .crc_start, .lat, .crc_done);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    i = 0;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && i < 50)
    begin
      @(posedge clk_sys);
      i++;
    end
    if (i == 50)
      chk("waitrequest", 32'h0, 32'h1);
    rd_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [4:0] a,
    input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    chk(n, e, rd_v);
  endtask
  // one-cycle event pulse, then time for flags to settle
  task automatic ev(input logic [5:0] v);
    @(posedge clk_sys);
    evs <= v;
    @(posedge clk_sys);
    evs <= 6'h00;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic close_out();
    $display("Compared %0d errors %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    fails++;
    close_out();
  end
  initial
  begin
    reset_n = 1'b0;
    {avs_read, avs_write, wrbuf_active} = 3'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    evs = 6'h00;
    lat = 8'h02;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc("status", ST, 32'h00000000);
    rdc("mask", pffl_pkg::OFF_MASK, 32'h00000000);
    xfer(1'b1, pffl_pkg::OFF_MASK, 32'h0000000F);
    ev(6'h01);
    rdc("status", ST, 32'h00000000);
    ev(6'h03);
    rdc("status", ST, PF);
    chk("irq", 32'h1, 32'(irq));
    xfer(1'b1, CT, 32'h00000008);
    repeat (3) @(posedge clk_sys);
    chk("standby", 32'h0, 32'(standby_enter));
    ev(6'h01);
    rdc("status", ST, PF);
    xfer(1'b1, CT, 32'h00000009);
    repeat (3) @(posedge clk_sys);
    chk("standby", 32'h1, 32'(standby_enter));
    rdc("status", ST, 32'h00000000);
    xfer(1'b1, pffl_pkg::OFF_EVT, 32'h0000000F);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h0, 32'(irq));
    xfer(1'b1, CT, 32'h00000000);
    ev(6'h04);
    rdc("status", ST, PF);
    xfer(1'b1, CT, 32'h00000002);
    rdc("status", ST, 32'h00000000);
    wrbuf_active <= 1'b1;
    ev(6'h08);
    wrbuf_active <= 1'b0;
    rdc("status", ST, PF | AB);
    ev(6'h01);
    rdc("status", ST, PF);
    ev(6'h10);
    rdc("status", ST, 32'h00000000);
    ev(6'h20);
    chk("valid", 32'h1, 32'(status_valid));
    // ending equal to starting is the shortest range that must abort
    xfer(1'b1, pffl_pkg::OFF_SADDR, 32'h00000005);
    xfer(1'b1, pffl_pkg::OFF_EADDR, 32'h00000005);
    xfer(1'b1, CT, 32'h00000004);
    repeat (3) @(posedge clk_sys);
    chk("crc ready", 32'h1, 32'(crc_ready));
    rdc("status", ST, AB);
    xfer(1'b1, CT, 32'h00000001);
    rdc("status", ST, 32'h00000000);
    lat <= 8'h14;
    xfer(1'b1, pffl_pkg::OFF_EADDR, 32'h00000006);
    xfer(1'b1, CT, 32'h00000004);
    repeat (2) @(posedge clk_sys);
    chk("crc ready", 32'h0, 32'(crc_ready));
    for (int i = 0; i < 100 && crc_ready !== 1'b1; i++)
      @(posedge clk_sys);
    chk("crc ready", 32'h1, 32'(crc_ready));
    rdc("status", ST, 32'h00000000);
    rdc("unmapped", 5'h1C, 32'h00000000);
    xfer(1'b1, ST, 32'hFFFFFFFF);
    rdc("status", ST, 32'h00000000);
    close_out();
  end
endmodule
`default_nettype wire
